//--- core/cffb_pkg.sv
// constants, register map and field layout of the fault-flag bank
`default_nettype none
package cffb_pkg;
   // register indices; byte address is four times the index
   localparam logic [8:0] CFFB_IDX_OV_FLAGS = 9'h081;
   localparam logic [8:0] CFFB_IDX_UV_FLAGS = 9'h082;
   localparam logic [8:0] CFFB_IDX_WIRE_FLAGS = 9'h083;
   localparam logic [8:0] CFFB_IDX_TEMP_FLAGS = 9'h084;
   localparam logic [8:0] CFFB_IDX_GEN_FLAGS = 9'h085;
   localparam logic [8:0] CFFB_IDX_SETUP = 9'h086;
   localparam logic [8:0] CFFB_IDX_OV_LIMIT = 9'h087;
   localparam logic [8:0] CFFB_IDX_CTRL = 9'h0A0;
   localparam logic [8:0] CFFB_IDX_IRQ_STAT = 9'h0A1;
   localparam logic [8:0] CFFB_IDX_IRQ_MASK = 9'h0A2;

   // implemented bits of each register, reserved bits read zero
   localparam logic [15:0] CFFB_MASK_CELL = 16'h3FFF;
   localparam logic [15:0] CFFB_MASK_WIRE = 16'h7FFF;
   localparam logic [15:0] CFFB_MASK_TEMP = 16'h1F9F;
   localparam logic [15:0] CFFB_MASK_GEN = 16'h000F;
   localparam logic [15:0] CFFB_MASK_SETUP = 16'hCFFF;

   // reset values and clearing write values
   localparam logic [15:0] CFFB_RST_FLAGS = 16'h0000;
   localparam logic [15:0] CFFB_RST_SETUP = 16'h00B8;
   localparam logic [15:0] CFFB_RST_OV_LIMIT = 16'h7FFF;
   localparam logic [15:0] CFFB_CLR_ALL = 16'hFFFF;
   localparam logic [15:0] CFFB_CLR_GEN = 16'h000F;

   // fault setup fields
   localparam int CFFB_SCN_LSB = 0;
   localparam int CFFB_TOT_LSB = 4;
   localparam int CFFB_DIE_HEAT_TEST_ENABLE_BIT = 7;
   localparam int CFFB_THERMISTOR_TEST_ENABLE_LSB = 8;
   localparam int CFFB_GPIO_HEAT_TEST_ENABLE_LSB = 14;

   // over-temperature flag positions
   localparam int CFFB_TEMP_DIE_BIT = 0;
   localparam int CFFB_TEMP_THERM_LSB = 1;
   localparam int CFFB_TEMP_GPIO_LSB = 7;
   localparam int CFFB_TEMP_OPEN_LSB = 9;

   // general flag positions
   localparam int CFFB_GEN_UNDER_BIT = 0;
   localparam int CFFB_GEN_OVER_BIT = 1;
   localparam int CFFB_GEN_MEM_BIT = 2;
   localparam int CFFB_GEN_REG_BIT = 3;

   // confirmation channel map
   localparam int CFFB_CH_UV = 0;
   localparam int CFFB_CH_OV = 14;
   localparam int CFFB_CH_WIRE = 28;
   localparam int CFFB_CH_DIE = 43;
   localparam int CFFB_CH_THERM = 44;
   localparam int CFFB_CH_GPIO = 48;
   localparam int CFFB_CH_OPEN = 50;
   localparam int CFFB_CH_N = 54;

   // interrupt event bits, control bit
   localparam int CFFB_EV_UV = 0;
   localparam int CFFB_EV_OV = 1;
   localparam int CFFB_EV_WIRE = 2;
   localparam int CFFB_EV_TEMP = 3;
   localparam int CFFB_EV_GEN = 4;
   localparam int CFFB_EV_SCAN = 5;
   localparam int CFFB_EV_W = 6;
   localparam int CFFB_CTRL_OVR_BIT = 0;

   // scan timing
   localparam int unsigned CFFB_CLK_KHZ = 20000;
   localparam int unsigned CFFB_SCAN_BASE_MS = 16;
   localparam int unsigned CFFB_SCAN_BASE_CYCLES =
      CFFB_SCAN_BASE_MS * CFFB_CLK_KHZ;
endpackage : cffb_pkg
`default_nettype wire

//--- core/cffb_confirm.sv
// per-channel run counters that confirm a fault after consecutive samples
`timescale 1ns/100ps
`default_nettype none
module cffb_confirm #(
   parameter int N = 54,
   parameter int CW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic sample_valid,
   input wire logic [N-1:0] sample,
   input wire logic [2:0] code,
   output logic [N-1:0] confirm
);
   typedef struct packed {
      logic [N-1:0][CW-1:0] cnt;
      logic [N-1:0] hit;
   } cffb_conf_state_t;

   cffb_conf_state_t st_reg;
   cffb_conf_state_t st_next;
   logic [CW-1:0] thr;

   // run length is two to the power of the code, 1 up to 128
   assign thr = CW'(1) << code;

   // count consecutive positives, hold at the threshold
   always_comb begin
      st_next = st_reg;
      st_next.hit = '0;
      if (sample_valid) begin
         for (int i = 0; i < N; i++) begin
            if (!sample[i]) begin
               st_next.cnt[i] = '0;
            end else if (st_reg.cnt[i] + CW'(1) >= thr) begin
               // holding keeps refiring after a clear, as the flag expects
               st_next.cnt[i] = thr;
               st_next.hit[i] = 1'b1;
            end else begin
               st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign confirm = st_reg.hit;
endmodule : cffb_confirm
`default_nettype wire

//--- core/cffb_bank.sv
// fault-flag register bank with apb slave, scan timer and interrupt
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - The wire break register holds fifteen flags, one per cell input pin.
// - Every fault flag resets to zero, sets on a fault and stays set.
// - Writing all ones to wire break or over-temperature flags clears them.
// - After the override command the next write replaces the flag contents.
// - Over-temperature flags sit at bits 0, 1 to 4, 7 to 8 and 9 to 12.
// - The die flag sets when die temperature exceeds its limit.
// - Writing 000F hex to the general register clears its four flags.
// - After each scan a memory signature is compared with the stored one.
// - The scan interval is 16 ms times two to the interval code.
// - A fault is confirmed after two to the code consecutive positives.
// - An enabled thermistor reading below the limit sets its heat flag.
// - The checksum summary is the OR of both checksum error flags.
// - The buffer summary is the OR of the underrun and overrun flags.
module cffb_bank
   import cffb_pkg::*;
#(
   parameter int unsigned SCAN_BASE_CYCLES = CFFB_SCAN_BASE_CYCLES,
   parameter int CELLS = 14,
   parameter int THERMS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic [CELLS*16-1:0] cell_reading,
   input wire logic [CELLS-1:0] cell_low_voltage_sample,
   input wire logic [CELLS:0] cell_wire_break_sample,
   input wire logic [THERMS*16-1:0] thermistor_input,
   input wire logic [15:0] ext_temp_limit,
   input wire logic [15:0] die_temp,
   input wire logic [15:0] die_temp_limit,
   input wire logic [1:0] gpio_heat_sample,
   input wire logic [THERMS-1:0] thermistor_open_sample,
   input wire logic buffer_underrun_event,
   input wire logic buffer_overrun_event,
   input wire logic register_checksum_event,
   input wire logic mem_word_valid,
   input wire logic [15:0] mem_word,
   input wire logic mem_word_last,
   input wire logic [15:0] mem_signature,
   output logic scan_tick,
   output logic checksum_error_summary,
   output logic buffer_error_summary,
   output logic irq
);
   typedef struct packed {
      logic [15:0] uv;
      logic [15:0] ov;
      logic [15:0] wire_brk;
      logic [15:0] temp;
      logic [15:0] gen;
      logic [15:0] setup;
      logic [15:0] ov_limit;
      logic ovr_armed;
      logic [CFFB_EV_W-1:0] irq_stat;
      logic [CFFB_EV_W-1:0] irq_mask;
      logic [35:0] scan_cnt;
      logic scan_tick;
      logic [15:0] signature_checksum;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic cksum_sum;
      logic buf_sum;
   } cffb_state_t;

   cffb_state_t st_reg;
   cffb_state_t st_next;
   logic [CFFB_CH_N-1:0] raw;
   logic [CFFB_CH_N-1:0] hit;

   // map a byte address to a register index, flag unmapped ones
   function automatic logic [9:0] cffb_decode(input logic [11:0] a);
      logic [8:0] idx;
      logic ok;
      idx = a[10:2];
      ok = 1'b0;
      if (a[11] || a[1:0] != 2'b00) begin
         ok = 1'b0;
      end else if (idx >= CFFB_IDX_OV_FLAGS && idx <= CFFB_IDX_OV_LIMIT) begin
         ok = 1'b1;
      end else if (idx >= CFFB_IDX_CTRL && idx <= CFFB_IDX_IRQ_MASK) begin
         ok = 1'b1;
      end
      return {ok, idx};
   endfunction : cffb_decode

   // write effect on one flag register
   function automatic logic [15:0] cffb_flag_wr(input logic [15:0] cur,
                                                input logic [15:0] wd,
                                                input logic [15:0] clr,
                                                input logic [15:0] msk,
                                                input logic armed,
                                                input logic sel);
      logic [15:0] r;
      r = cur;
      if (sel && armed) begin
         r = wd & msk;
      end else if (sel && wd == clr) begin
         r = CFFB_RST_FLAGS;
      end
      return r;
   endfunction : cffb_flag_wr

   // signature register step over one memory word
   function automatic logic [15:0] cffb_signature_checksum(input logic [15:0] s,
                                             input logic [15:0] d);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]} ^ d;
   endfunction : cffb_signature_checksum

   // raw per-sample fault conditions, die, thermistor and gpio heat ones gated by the test enables
   always_comb begin
      raw = '0;
      for (int i = 0; i < CELLS; i++) begin
         raw[CFFB_CH_UV + i] = cell_low_voltage_sample[i];
         raw[CFFB_CH_OV + i] = $signed(cell_reading[i*16 +: 16]) >
                               $signed(st_reg.ov_limit);
      end
      for (int i = 0; i <= CELLS; i++) begin
         raw[CFFB_CH_WIRE + i] = cell_wire_break_sample[i];
      end
      // lower thermistor reading means hotter
      for (int i = 0; i < THERMS; i++) begin
         raw[CFFB_CH_THERM + i] = st_reg.setup[CFFB_THERMISTOR_TEST_ENABLE_LSB + i] &&
            (thermistor_input[i*16 +: 16] < ext_temp_limit);
         raw[CFFB_CH_OPEN + i] = thermistor_open_sample[i];
      end
      raw[CFFB_CH_DIE] = st_reg.setup[CFFB_DIE_HEAT_TEST_ENABLE_BIT] &&
                         (die_temp > die_temp_limit);
      for (int i = 0; i < 2; i++) begin
         raw[CFFB_CH_GPIO + i] = st_reg.setup[CFFB_GPIO_HEAT_TEST_ENABLE_LSB + i] &&
                                 gpio_heat_sample[i];
      end
   end

   cffb_confirm #(
      .N(CFFB_CH_N),
      .CW(8)
   ) u_confirm (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sample_valid(sample_valid),
      .sample(raw),
      .code(st_reg.setup[CFFB_TOT_LSB +: 3]),
      .confirm(hit)
   );

   // apb, register writes, flag setting, scan timer and interrupt
   always_comb begin
      logic [9:0] dec;
      logic done;
      logic wr;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [15:0] set_uv;
      logic [15:0] set_ov;
      logic [15:0] set_wire;
      logic [15:0] set_temp;
      logic [15:0] set_gen;
      logic [CFFB_EV_W-1:0] ev;
      logic mem_err;
      st_next = st_reg;
      dec = cffb_decode(paddr);
      done = psel && penable && st_reg.pready;
      wr = done && pwrite && dec[9];
      wd = pwdata[15:0];
      rd = '0;
      set_uv = '0;
      set_ov = '0;
      set_wire = '0;
      set_temp = '0;
      set_gen = '0;
      ev = '0;
      mem_err = 1'b0;

      // setup phase latches read data; access ends one cycle later
      st_next.pready = 1'b0;
      if (psel && !penable) begin
         if (dec[8:0] == CFFB_IDX_OV_FLAGS) begin
            rd = st_reg.ov;
         end else if (dec[8:0] == CFFB_IDX_UV_FLAGS) begin
            rd = st_reg.uv;
         end else if (dec[8:0] == CFFB_IDX_WIRE_FLAGS) begin
            rd = st_reg.wire_brk;
         end else if (dec[8:0] == CFFB_IDX_TEMP_FLAGS) begin
            rd = st_reg.temp;
         end else if (dec[8:0] == CFFB_IDX_GEN_FLAGS) begin
            rd = st_reg.gen;
         end else if (dec[8:0] == CFFB_IDX_SETUP) begin
            rd = st_reg.setup;
         end else if (dec[8:0] == CFFB_IDX_OV_LIMIT) begin
            rd = st_reg.ov_limit;
         end else if (dec[8:0] == CFFB_IDX_CTRL) begin
            rd[CFFB_CTRL_OVR_BIT] = st_reg.ovr_armed;
         end else if (dec[8:0] == CFFB_IDX_IRQ_STAT) begin
            rd[CFFB_EV_W-1:0] = st_reg.irq_stat;
         end else if (dec[8:0] == CFFB_IDX_IRQ_MASK) begin
            rd[CFFB_EV_W-1:0] = st_reg.irq_mask;
         end
         st_next.prdata = {16'h0000, dec[9] ? rd : 16'h0000};
         st_next.pslverr = !dec[9];
         st_next.pready = 1'b1;
      end

      // plain register writes
      if (wr && dec[8:0] == CFFB_IDX_SETUP) begin
         st_next.setup = wd & CFFB_MASK_SETUP;
      end
      if (wr && dec[8:0] == CFFB_IDX_OV_LIMIT) begin
         st_next.ov_limit = wd;
      end
      if (wr && dec[8:0] == CFFB_IDX_IRQ_MASK) begin
         st_next.irq_mask = wd[CFFB_EV_W-1:0];
      end

      // flag registers: clear or direct write first, then new sets on top
      st_next.uv = cffb_flag_wr(st_reg.uv, wd, CFFB_CLR_ALL, CFFB_MASK_CELL,
         st_reg.ovr_armed, wr && dec[8:0] == CFFB_IDX_UV_FLAGS);
      st_next.ov = cffb_flag_wr(st_reg.ov, wd, CFFB_CLR_ALL, CFFB_MASK_CELL,
         st_reg.ovr_armed, wr && dec[8:0] == CFFB_IDX_OV_FLAGS);
      st_next.wire_brk = cffb_flag_wr(st_reg.wire_brk, wd, CFFB_CLR_ALL,
         CFFB_MASK_WIRE, st_reg.ovr_armed,
         wr && dec[8:0] == CFFB_IDX_WIRE_FLAGS);
      st_next.temp = cffb_flag_wr(st_reg.temp, wd, CFFB_CLR_ALL,
         CFFB_MASK_TEMP, st_reg.ovr_armed,
         wr && dec[8:0] == CFFB_IDX_TEMP_FLAGS);
      st_next.gen = cffb_flag_wr(st_reg.gen, wd, CFFB_CLR_GEN, CFFB_MASK_GEN,
         st_reg.ovr_armed, wr && dec[8:0] == CFFB_IDX_GEN_FLAGS);

      // override arms on the command, any other accepted write consumes it
      if (wr && dec[8:0] == CFFB_IDX_CTRL) begin
         st_next.ovr_armed = wd[CFFB_CTRL_OVR_BIT];
      end else if (wr) begin
         st_next.ovr_armed = 1'b0;
      end

      // confirmed faults
      set_uv[CELLS-1:0] = hit[CFFB_CH_UV +: CELLS];
      set_ov[CELLS-1:0] = hit[CFFB_CH_OV +: CELLS];
      set_wire[CELLS:0] = hit[CFFB_CH_WIRE +: CELLS + 1];
      set_temp[CFFB_TEMP_DIE_BIT] = hit[CFFB_CH_DIE];
      set_temp[CFFB_TEMP_THERM_LSB +: THERMS] = hit[CFFB_CH_THERM +: THERMS];
      set_temp[CFFB_TEMP_GPIO_LSB +: 2] = hit[CFFB_CH_GPIO +: 2];
      set_temp[CFFB_TEMP_OPEN_LSB +: THERMS] = hit[CFFB_CH_OPEN +: THERMS];

      // memory signature accumulates after each scan tick
      if (st_reg.scan_tick) begin
         st_next.signature_checksum = '0;
      end else if (mem_word_valid) begin
         st_next.signature_checksum = cffb_signature_checksum(st_reg.signature_checksum, mem_word);
         mem_err = mem_word_last &&
                   cffb_signature_checksum(st_reg.signature_checksum, mem_word) != mem_signature;
      end
      set_gen[CFFB_GEN_UNDER_BIT] = buffer_underrun_event;
      set_gen[CFFB_GEN_OVER_BIT] = buffer_overrun_event;
      set_gen[CFFB_GEN_MEM_BIT] = mem_err;
      set_gen[CFFB_GEN_REG_BIT] = register_checksum_event;

      // a set in the same cycle as a clear wins
      st_next.uv = st_next.uv | set_uv;
      st_next.ov = st_next.ov | set_ov;
      st_next.wire_brk = st_next.wire_brk | set_wire;
      st_next.temp = st_next.temp | set_temp;
      st_next.gen = st_next.gen | set_gen;

      // scan interval timer, reload from the current code
      st_next.scan_tick = 1'b0;
      if (st_reg.scan_cnt == '0) begin
         st_next.scan_cnt = (36'(SCAN_BASE_CYCLES) <<
                             st_reg.setup[CFFB_SCN_LSB +: 4]) - 36'h1;
         st_next.scan_tick = 1'b1;
      end else begin
         st_next.scan_cnt = st_reg.scan_cnt - 36'h1;
      end

      // sticky events, write one to clear, set wins
      ev[CFFB_EV_UV] = |set_uv;
      ev[CFFB_EV_OV] = |set_ov;
      ev[CFFB_EV_WIRE] = |set_wire;
      ev[CFFB_EV_TEMP] = |set_temp;
      ev[CFFB_EV_GEN] = |set_gen;
      ev[CFFB_EV_SCAN] = st_reg.scan_tick;
      if (wr && dec[8:0] == CFFB_IDX_IRQ_STAT) begin
         st_next.irq_stat = st_reg.irq_stat & ~wd[CFFB_EV_W-1:0];
      end
      st_next.irq_stat = st_next.irq_stat | ev;
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

      // summary bits follow the flags they combine
      st_next.cksum_sum = st_next.gen[CFFB_GEN_REG_BIT] |
                          st_next.gen[CFFB_GEN_MEM_BIT];
      st_next.buf_sum = st_next.gen[CFFB_GEN_UNDER_BIT] |
                        st_next.gen[CFFB_GEN_OVER_BIT];
   end

   // single state register; first scan tick comes right after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.setup <= CFFB_RST_SETUP;
         st_reg.ov_limit <= CFFB_RST_OV_LIMIT;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign scan_tick = st_reg.scan_tick;
   assign checksum_error_summary = st_reg.cksum_sum;
   assign buffer_error_summary = st_reg.buf_sum;
   assign irq = st_reg.irq;
endmodule : cffb_bank
`default_nettype wire

//--- test/cffb_monitor.sv
// concurrent checks on the bus side and fault summaries of the flag bank
`timescale 1ns/100ps
`default_nettype none
module cffb_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic buffer_underrun_event,
   input wire logic buffer_overrun_event,
   input wire logic register_checksum_event,
   input wire logic scan_tick,
   input wire logic checksum_error_summary,
   input wire logic buffer_error_summary
);
   logic armed_reg;
   logic armed_next;
   logic wdone;
   logic gen_wr;
   // track the override arm, any other accepted write consumes it
   assign wdone = psel && penable && pwrite && pready && !pslverr;
   assign gen_wr = wdone && paddr == 12'h214 && !armed_reg;
   always_comb begin
      armed_next = armed_reg;
      if (wdone) armed_next = (paddr == 12'h280) ? pwdata[0] : 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) armed_reg <= 1'b0;
      else armed_reg <= armed_next;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_answer;
      psel && !penable && ce |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer to setup");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_refuse;
      psel && !penable && paddr < 12'h204 |=> pslverr && prdata == 32'h0;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped not refused");
   property p_buf_sum;
      buffer_underrun_event || buffer_overrun_event |=> buffer_error_summary;
   endproperty
   a_buf_sum: assert property (p_buf_sum)
      else $error("buffer summary missing");
   property p_chk_sum;
      register_checksum_event |=> checksum_error_summary;
   endproperty
   a_chk_sum: assert property (p_chk_sum)
      else $error("checksum summary missing");
   property p_sticky;
      $fell(buffer_error_summary) |-> $past(gen_wr);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("summary dropped without clear");
   property p_gen_keep;
      gen_wr && pwdata[15:0] != 16'h000F && buffer_error_summary
         |=> buffer_error_summary;
   endproperty
   a_gen_keep: assert property (p_gen_keep)
      else $error("plain write cleared flags");
   property p_gen_clear;
      gen_wr && pwdata[15:0] == 16'h000F && !buffer_underrun_event
         && !buffer_overrun_event |=> !buffer_error_summary;
   endproperty
   a_gen_clear: assert property (p_gen_clear)
      else $error("clear value ignored");
   property p_tick;
      scan_tick |=> !scan_tick [*3];
   endproperty
   a_tick: assert property (p_tick) else $error("scan ticks too close");
endmodule : cffb_monitor
`default_nettype wire

//--- test/cffb_host.sv
// host model issuing register reads and writes over apb
`timescale 1ns/100ps
`default_nettype none
module cffb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [31:0] rdata;
   logic rerr;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // one transfer; released bus shows inverted values, not stale ones
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [15:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~{16'h0000, d};
      @(posedge pclk);
   endtask : xfer
   // direct write: arm the override, then replace the contents
   task automatic direct(input logic [11:0] a, input logic [15:0] d);
      xfer(1'b1, 12'h280, 16'h0001);
      xfer(1'b1, a, d);
   endtask : direct
endmodule : cffb_host
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the fault-flag register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, sample_valid, scan_tick, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic checksum_error_summary, buffer_error_summary;
   logic [223:0] cell_reading = '0;
   logic [13:0] cell_low_voltage_sample = '0;
   logic [14:0] cell_wire_break_sample = '0;
   logic [63:0] thermistor_input = '0;
   logic [15:0] ext_temp_limit = '0, die_temp = '0, die_temp_limit = '0;
   logic [15:0] mem_word = '0, mem_signature = '0;
   logic [1:0] gpio_heat_sample = '0;
   logic [3:0] thermistor_open_sample = '0;
   logic buffer_underrun_event = 1'b0, buffer_overrun_event = 1'b0;
   logic register_checksum_event = 1'b0, mem_word_valid = 1'b0;
   logic mem_word_last = 1'b0;
   int failures, checked, n, mdl [int];
   cffb_bank #(.SCAN_BASE_CYCLES(4)) uut (.pclk, .presetn, .ce, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sample_valid, .cell_reading, .cell_low_voltage_sample,
      .cell_wire_break_sample, .thermistor_input, .ext_temp_limit, .die_temp,
      .die_temp_limit, .gpio_heat_sample, .thermistor_open_sample,
      .buffer_underrun_event, .buffer_overrun_event, .register_checksum_event,
      .mem_word_valid, .mem_word, .mem_word_last, .mem_signature, .scan_tick,
      .checksum_error_summary, .buffer_error_summary, .irq);
   cffb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   always #25 pclk = ~pclk;
   task automatic stop_test();
      if (failures == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic rd(input int a);
      host.xfer(1'b0, a[11:0], 16'h0000);
      `CHK("read data", 32'(mdl[a]), host.rdata)
   endtask : rd
   // model: plain writes keep flags, only the clear value empties them
   task automatic wr(input int a, input int d);
      host.xfer(1'b1, a[11:0], d[15:0]);
      if (a == 'h218) mdl[a] = d & 'hCFFF;
      else if (a == 'h21C) mdl[a] = d;
      else if (d == (a == 'h214 ? 'hF : 'hFFFF)) mdl[a] = 0;
   endtask : wr
   // one sample set; the model folds it in only when upd is set
   task automatic smp(input logic [14:0] w, input logic [13:0] u, bit upd);
      int t;
      sample_valid <= 1'b1;
      cell_wire_break_sample <= w;
      cell_low_voltage_sample <= u;
      cell_reading <= {7{$urandom}};
      thermistor_input <= {$urandom, $urandom};
      gpio_heat_sample <= 2'($urandom);
      thermistor_open_sample <= 4'($urandom);
      die_temp <= 16'($urandom);
      die_temp_limit <= 16'($urandom);
      ext_temp_limit <= 16'($urandom);
      @(posedge pclk);
      sample_valid <= 1'b0;
      @(posedge pclk);
      if (upd) begin
         mdl['h20C] |= w;
         mdl['h208] |= u;
         t = int'(die_temp > die_temp_limit) | (gpio_heat_sample << 7);
         t |= thermistor_open_sample << 9;
         for (int j = 0; j < 4; j++) begin
            if (thermistor_input[16*j +: 16] < ext_temp_limit) t |= 2 << j;
         end
         mdl['h210] |= t;
         for (int i = 0; i < 14; i++) begin
            if ($signed(cell_reading[16*i +: 16]) > $signed(mdl['h21C][15:0]))
               mdl['h204] |= 1 << i;
         end
      end
   endtask : smp
   task automatic tick(output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (scan_tick !== 1'b1 && c < 5000);
   endtask : tick
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end
   initial begin
      logic [15:0] s, w16;
      void'($urandom(70674));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 'h204; a <= 'h214; a += 4) mdl[a] = 0;
      mdl['h218] = 'hB8;
      mdl['h21C] = 'h7FFF;
      for (int a = 'h204; a <= 'h21C; a += 4) rd(a);
      host.xfer(1'b0, 12'h000, 16'h0000);
      `CHK("refused", 33'h100000000, {host.rerr, host.rdata})
      wr('h218, 'hCF84);
      wr('h21C, $urandom & 'h3FFF);
      smp(15'($urandom), 14'($urandom), 1);
      for (int a = 'h204; a <= 'h210; a += 4) rd(a);
      // wire event: raise, mask off, clear while masked
      host.xfer(1'b1, 12'h288, 16'h0004);
      repeat (2) @(posedge pclk);
      `CHK("irq raised", 1'b1, irq)
      host.xfer(1'b1, 12'h288, 16'h0000);
      repeat (2) @(posedge pclk);
      `CHK("irq masked", 1'b0, irq)
      host.xfer(1'b1, 12'h284, 16'h003F);
      host.xfer(1'b1, 12'h288, 16'h0004);
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      wr('h20C, 'h1234);
      rd('h20C);
      wr('h20C, 'hFFFF);
      rd('h20C);
      wr('h210, 'hFFFF);
      rd('h210);
      host.direct(12'h210, 16'h0A05);
      mdl['h210] = 'h0A05;
      rd('h210);
      // run of four: a gap restarts the count
      wr('h218, 'hCFA4);
      smp(15'h0, 14'h0, 0);
      repeat (3) smp(15'h4001, 14'h0, 0);
      smp(15'h0, 14'h0, 0);
      repeat (3) smp(15'h4001, 14'h0, 0);
      rd('h20C);
      smp(15'h4001, 14'h0, 1);
      rd('h20C);
      wr('h218, 'hCF84);
      buffer_underrun_event <= 1'b1;
      buffer_overrun_event <= 1'b1;
      @(posedge pclk);
      buffer_underrun_event <= 1'b0;
      buffer_overrun_event <= 1'b0;
      register_checksum_event <= 1'b1;
      @(posedge pclk);
      register_checksum_event <= 1'b0;
      @(posedge pclk);
      mdl['h214] = 'hB;
      `CHK("buffer summary", 1'b1, buffer_error_summary)
      `CHK("checksum summary", 1'b1, checksum_error_summary)
      wr('h214, 'h0005);
      rd('h214);
      wr('h214, 'h000F);
      rd('h214);
      `CHK("summary cleared", 1'b0, buffer_error_summary)
      tick(n);
      ce <= 1'b0; // frozen cycles must not count toward the interval
      repeat (8) @(posedge pclk);
      ce <= 1'b1;
      tick(n);
      `CHK("scan interval", 4 << 4, n)
      // signature restarts after the tick; first run matches, second is off
      repeat (2) @(posedge pclk);
      s = 16'h0000;
      for (int k = 0; k < 6; k++) begin
         w16 = 16'($urandom);
         s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]} ^ w16;
         mem_word_valid <= 1'b1;
         mem_word <= w16;
         mem_word_last <= (k % 3 == 2);
         mem_signature <= s ^ 16'(k / 3);
         if (k == 4) `CHK("mem ok", 1'b0, checksum_error_summary)
         @(posedge pclk);
      end
      mem_word_valid <= 1'b0;
      mem_word_last <= 1'b0;
      @(posedge pclk);
      mdl['h214] = 4;
      rd('h214);
      `CHK("checksum summary", 1'b1, checksum_error_summary)
      stop_test();
   end
endmodule : tb_top
bind cffb_bank cffb_monitor mon (.pclk, .presetn, .ce, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .buffer_underrun_event, .buffer_overrun_event, .register_checksum_event,
   .scan_tick, .checksum_error_summary, .buffer_error_summary);
`default_nettype wire
